// file: src/can_bit_timing_pkg.sv
// Purpose: constants for the can bit timing block
// Assumes: apb slave with 32-bit data, pclk at 10 MHz
// Notes:   offsets are byte addresses, one word per register
package can_bit_timing_pkg;
	// ****************************************
	// register map
	// ****************************************
	localparam logic [11:0] OFF_BIT_TIMING     = 12'h000C;
	localparam logic [11:0] OFF_PRESCALER_EXT  = 12'h0018;
	localparam logic [11:0] OFF_LINK_CTRL      = 12'h0040;
	localparam logic [11:0] OFF_LINK_STATUS    = 12'h0044;
	localparam logic [15:0] BIT_TIMING_RESET   = 16'h2301;
	localparam logic [3:0]  PRESCALER_EXT_RESET = 4'h0;
	// ****************************************
	// field positions of bit_timing_config
	// ****************************************
	localparam int PRESC_LSB = 0;
	localparam int JUMP_LSB  = 6;
	localparam int SEG1_LSB  = 8;
	localparam int SEG2_LSB  = 12;
	// ****************************************
	// timing figures
	// ****************************************
	localparam int CLK_MHZ             = 10;
	localparam int CTRL_CLK_MHZ        = 8;
	localparam int PROCESSING_DELAY_TQ = 0;
	localparam int SEG2_MIN_TQ         = 1;
	// states of the bit walk
	typedef enum logic [3:0] {
		SEG_SYNC  = 4'b0001,
		SEG_ONE   = 4'b0010,
		SEG_TWO   = 4'b0100,
		SEG_IDLE  = 4'b1000
	} seg_state_t;
endpackage

// file: src/can_bit_timing_logic.sv
// Purpose: can bit timing logic with apb register access
// Assumes: rx input synchronous to pclk, tx recessive high
// Notes:   frame-level processing is outside; this block gives sample and tx commit strobes
// Operation
// - quantum length is prescaler count of input clocks
// - quanta are counted from the controller clock, run here as pclk
// - bit made of sync, propagation, phase one and phase two segments
// - sync segment lasts exactly one quantum
// - phase error is the edge distance from sync segment
// - propagation segment one to eight quanta; here it has no field or state of its own and is counted inside SEG_ONE
// - phase one one to eight quanta, lengthened by resync; here one seg1 field sets propagation plus phase one, 1 to 16
// - phase two one to eight quanta, shortened by resync
// - jump width one to four, limits each resync shift
// - prescaler 1 to 64, extension widens to 1024
// - fields hold functional value minus one
// - bit time is segment fields plus three quanta
// - register contents drive the timing logic directly
// - timing decisions are taken once per quantum
// - receive sample and transmit commit at the sample point
// - framing, stuffing, crc and error work happen downstream using strobes
// - processing delay is zero quanta
// - phase two never programmed below processing delay
// - supports bit rates below 1 kbps to 1000 kbps
// - bit time four to twenty-five quanta; the fields here allow three to twenty-five
//
// Our own choices: the address map and the APB interface to the registers.
`timescale 1ns/100ps
module can_bit_timing_logic
(
	// apb
	input  wire logic        pclk,
	input  wire logic        presetn,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// can link
	input  wire logic        can_rx,
	input  wire logic        tx_bit,
	output logic             can_tx,
	output logic             sample_strobe,
	output logic             sample_value,
	output logic             tx_commit
);
	// ****************************************
	// registers
	// ****************************************
	logic [15:0] bit_timing_q;
	logic [3:0]  prescaler_ext_q;
	logic        enable_q;
	logic        bus_idle_q;
	logic [9:0]  tq_cnt_q;
	logic [4:0]  seg_cnt_q;
	logic [4:0]  seg1_len_q;
	logic        rx_prev_q;
	logic        synced_q;
	can_bit_timing_pkg::seg_state_t state_q;
	logic [3:0]  idle_cnt_q;

	// apb decode
	wire        setup_ph = psel && !penable;
	wire        access   = psel && penable;
	wire        wr_en    = access && pwrite;
	wire        hit_bt   = paddr == can_bit_timing_pkg::OFF_BIT_TIMING;
	wire        hit_pe   = paddr == can_bit_timing_pkg::OFF_PRESCALER_EXT;
	wire        hit_ct   = paddr == can_bit_timing_pkg::OFF_LINK_CTRL;
	wire        hit_st   = paddr == can_bit_timing_pkg::OFF_LINK_STATUS;
	wire        hit_any  = hit_bt || hit_pe || hit_ct || hit_st;

	// field decode; values are stored minus one
	wire [5:0]  presc_f  = bit_timing_q[can_bit_timing_pkg::PRESC_LSB +: 6];
	wire [1:0]  jump_f   = bit_timing_q[can_bit_timing_pkg::JUMP_LSB +: 2];
	wire [3:0]  seg1_f   = bit_timing_q[can_bit_timing_pkg::SEG1_LSB +: 4];
	wire [2:0]  seg2_f   = bit_timing_q[can_bit_timing_pkg::SEG2_LSB +: 3];
	wire [9:0]  presc_all = {prescaler_ext_q, presc_f};
	wire [4:0]  seg1_tq  = {1'b0, seg1_f} + 5'd1;
	wire [4:0]  seg2_tq  = {2'b00, seg2_f} + 5'd1;
	wire [4:0]  jump_tq  = {3'b000, jump_f} + 5'd1;

	// one quantum elapses each prescaler count of clocks
	// a ten-bit prescaler reaches 1024 clocks a quantum, so very slow bit rates are covered
	wire        tq_tick  = enable_q && (tq_cnt_q == presc_all);
	wire        fall     = rx_prev_q && !can_rx;
	wire        seg1_end = (state_q == can_bit_timing_pkg::SEG_ONE) && (seg_cnt_q + 5'd1 >= seg1_len_q);
	// phase error: quanta still left in phase two at the edge
	wire [4:0]  err_two  = seg2_tq - seg_cnt_q;
	wire [4:0]  err_one  = seg_cnt_q + 5'd1;
	function automatic logic [4:0] min5(input logic [4:0] a, input logic [4:0] b);
		min5 = (a < b) ? a : b;
	endfunction
	wire [4:0]  lengthen = min5(err_one, jump_tq);
	wire [4:0]  shorten  = min5(err_two, jump_tq);
	// phase two ends at its full count, or at an edge whose error the jump width covers
	wire        seg2_end = (state_q == can_bit_timing_pkg::SEG_TWO) &&
		((seg_cnt_q + 5'd1 >= seg2_tq) || (fall && !synced_q && shorten >= err_two));
	wire [31:0] rd_mux   = hit_bt ? {16'h0000, bit_timing_q} :
		hit_pe ? {28'h0000_000, prescaler_ext_q} :
		hit_ct ? {31'h0, enable_q} :
		hit_st ? {27'h0, bus_idle_q, state_q} : 32'h0000_0000;

	// ****************************************
	// apb slave: zero wait, error on unmapped address
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			bit_timing_q    <= can_bit_timing_pkg::BIT_TIMING_RESET;
			prescaler_ext_q <= can_bit_timing_pkg::PRESCALER_EXT_RESET;
			enable_q        <= 1'b0;
		end
		else if (wr_en)
		begin
			if (hit_bt)
				bit_timing_q <= pwdata[15:0] & 16'h7FFF;
			if (hit_pe)
				prescaler_ext_q <= pwdata[3:0];
			if (hit_ct)
				enable_q <= pwdata[0];
		end
	end

	// read data and response registered in the setup cycle
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			prdata  <= 32'h0000_0000;
			pready  <= 1'b0;
			pslverr <= 1'b0;
		end
		else
		begin
			prdata  <= setup_ph ? rd_mux : prdata;
			pready  <= setup_ph;
			pslverr <= setup_ph && !hit_any;
		end
	end

	// ****************************************
	// quantum prescaler
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			tq_cnt_q <= 10'h000;
		else if (!enable_q || tq_tick)
			tq_cnt_q <= 10'h000;
		else
			tq_cnt_q <= tq_cnt_q + 10'd1;
	end

	// ****************************************
	// bit segment walk, one step per quantum
	// ****************************************
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			state_q    <= can_bit_timing_pkg::SEG_IDLE;
			seg_cnt_q  <= 5'h00;
			seg1_len_q <= 5'h01;
			rx_prev_q  <= 1'b1;
			synced_q   <= 1'b0;
			bus_idle_q <= 1'b1;
			idle_cnt_q <= 4'h0;
			sample_strobe <= 1'b0;
			sample_value  <= 1'b1;
			tx_commit     <= 1'b0;
			can_tx        <= 1'b1;
		end
		else
		begin
			sample_strobe <= 1'b0;
			tx_commit     <= 1'b0;
			if (!enable_q)
			begin
				state_q    <= can_bit_timing_pkg::SEG_IDLE;
				bus_idle_q <= 1'b1;
				can_tx     <= 1'b1;
				rx_prev_q  <= 1'b1;
			end
			else if (tq_tick)
			begin
				rx_prev_q <= can_rx;
				unique case (state_q)
				can_bit_timing_pkg::SEG_IDLE:
				begin
					if (fall)
					begin
						// hard sync: this quantum counts as sync
						state_q    <= can_bit_timing_pkg::SEG_ONE;
						seg_cnt_q  <= 5'h00;
						seg1_len_q <= seg1_tq;
						synced_q   <= 1'b1;
						bus_idle_q <= 1'b0;
					end
				end
				can_bit_timing_pkg::SEG_SYNC:
				begin
					state_q    <= can_bit_timing_pkg::SEG_ONE;
					seg_cnt_q  <= 5'h00;
					seg1_len_q <= seg1_tq;
					synced_q   <= fall;
				end
				can_bit_timing_pkg::SEG_ONE:
				begin
					// late edge: stretch phase one
					if (fall && !synced_q)
					begin
						seg1_len_q <= seg1_len_q + lengthen;
						synced_q   <= 1'b1;
						seg_cnt_q  <= seg_cnt_q + 5'd1;
					end
					else if (seg1_end)
					begin
						// sample point; zero processing delay so tx commits here too
						state_q       <= can_bit_timing_pkg::SEG_TWO;
						seg_cnt_q     <= 5'h00;
						sample_strobe <= 1'b1;
						sample_value  <= can_rx;
						tx_commit     <= 1'b1;
						can_tx        <= tx_bit;
					end
					else
						seg_cnt_q <= seg_cnt_q + 5'd1;
				end
				can_bit_timing_pkg::SEG_TWO:
				begin
					// early edge ends phase two; shortening below the delay is harmless
					if (seg2_end)
					begin
						state_q   <= can_bit_timing_pkg::SEG_SYNC;
						seg_cnt_q <= 5'h00;
						idle_cnt_q <= (sample_value) ? idle_cnt_q + 4'd1 : 4'h0;
						if (sample_value && idle_cnt_q == 4'd10)
						begin
							state_q    <= can_bit_timing_pkg::SEG_IDLE;
							bus_idle_q <= 1'b1;
							idle_cnt_q <= 4'h0;
						end
					end
					else if (fall && !synced_q)
					begin
						// edge too early for one jump: phase two is cut by the jump width only,
						// the rest of the phase error is left for later bits
						seg_cnt_q <= seg_cnt_q + 5'd1 + shorten;
						synced_q  <= 1'b1;
					end
					else
						seg_cnt_q <= seg_cnt_q + 5'd1;
				end
				endcase
			end
		end
	end

	// ****************************************
	// assertion helpers
	// ****************************************
	// cycles spent in sync so far; a quantum may last 1024 clocks, which is
	// beyond what a delay range may span, so the length is counted instead
	// limitation: a prescaler rewrite in mid-quantum can make sync look long
	logic [10:0] sync_run_q;

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			sync_run_q <= 11'h000;
		else if (state_q == can_bit_timing_pkg::SEG_SYNC)
			sync_run_q <= sync_run_q + 11'd1;
		else
			sync_run_q <= 11'h000;
	end

	// ****************************************
	// checks
	// ****************************************
	chk_tick_spacing: assert property (@(posedge pclk) disable iff (!presetn)
		tq_tick && presc_all == 10'd0 && $past(enable_q) |-> $past(tq_tick))
		else $error("quantum tick spacing wrong");
	chk_sync_one: assert property (@(posedge pclk) disable iff (!presetn)
		state_q == can_bit_timing_pkg::SEG_SYNC |-> sync_run_q <= {1'b0, presc_all})
		else $error("sync segment too long");
	chk_state_onehot: assert property (@(posedge pclk) disable iff (!presetn)
		$onehot(state_q))
		else $error("segment state not one-hot");
	chk_resp_pair: assert property (@(posedge pclk) disable iff (!presetn)
		pslverr |-> pready)
		else $error("error response without ready");
	chk_sample_seg: assert property (@(posedge pclk) disable iff (!presetn)
		sample_strobe |-> state_q == can_bit_timing_pkg::SEG_TWO)
		else $error("sample outside phase boundary");
	chk_commit_pair: assert property (@(posedge pclk) disable iff (!presetn)
		sample_strobe == tx_commit)
		else $error("commit not at sample point");
	chk_step_tick: assert property (@(posedge pclk) disable iff (!presetn)
		!tq_tick && enable_q && $past(enable_q) |=> $stable(state_q))
		else $error("state moved between quanta");
	chk_idle_hard: assert property (@(posedge pclk) disable iff (!presetn)
		enable_q && tq_tick && state_q == can_bit_timing_pkg::SEG_IDLE && fall
		|=> state_q == can_bit_timing_pkg::SEG_ONE)
		else $error("no hard sync");
	chk_jump_bound: assert property (@(posedge pclk) disable iff (!presetn)
		seg1_len_q <= seg1_tq + jump_tq || state_q != can_bit_timing_pkg::SEG_ONE)
		else $error("phase one stretched too far");
	chk_disable_tx: assert property (@(posedge pclk) disable iff (!presetn)
		!enable_q |=> can_tx)
		else $error("tx not recessive when disabled");
	cov_sample: cover property (@(posedge pclk) disable iff (!presetn) sample_strobe);
	cov_lengthen: cover property (@(posedge pclk) disable iff (!presetn)
		tq_tick && state_q == can_bit_timing_pkg::SEG_ONE && fall && !synced_q);
	cov_shorten: cover property (@(posedge pclk) disable iff (!presetn)
		tq_tick && state_q == can_bit_timing_pkg::SEG_TWO && fall && !synced_q);
	// hard sync out of idle and the fall back to idle after a recessive run
	cov_hard_sync: cover property (@(posedge pclk) disable iff (!presetn)
		tq_tick && state_q == can_bit_timing_pkg::SEG_IDLE && fall);
	cov_idle_return: cover property (@(posedge pclk) disable iff (!presetn)
		$rose(bus_idle_q) && enable_q);
endmodule // can_bit_timing_logic

// file: dv/can_node_model.sv
// Purpose: one other node on the can bus, seen through its transceiver
// Assumes: wired-and bus with a pull-up, so recessive (1) when nobody pulls low
// Notes:   the bench sets the node's level just after a clock edge
`timescale 1ns/100ps
module can_node_model
(
	// clock
	input  wire logic pclk,
	// bus
	input  wire logic can_tx,
	output logic      can_rx
);
	logic drive_low_q;

	// ****************************************
	// bus level
	// ****************************************
	// dominant wins, so our own dominant bits also reach the receiver
	assign can_rx = can_tx & ~drive_low_q;
	initial drive_low_q = 1'b0;

	// set the level, then hold it for n clocks
	task automatic hold_level(input logic lvl, input int n);
		drive_low_q <= ~lvl;
		repeat (n) @(posedge pclk);
	endtask
endmodule // can_node_model

// file: dv/can_bit_timing_logic_tb_top.sv
// Purpose: self-checking bench for the can bit timing block
// Assumes: apb with one wait-free access cycle, pclk 100 ns
// Notes:   bit length is measured between two sample strobes with no edges between
`timescale 1ns/100ps
module can_bit_timing_logic_tb_top;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        can_rx;
	logic        tx_bit;
	logic        can_tx;
	logic        sample_strobe;
	logic        sample_value;
	logic        tx_commit;
	logic [31:0] rdat;
	logic        rerr;
	int          errors;
	int          checked;
	int          gap;

	can_bit_timing_logic u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .can_rx(can_rx), .tx_bit(tx_bit), .can_tx(can_tx),
		.sample_strobe(sample_strobe), .sample_value(sample_value), .tx_commit(tx_commit));
	can_node_model u_node (.pclk(pclk), .can_tx(can_tx), .can_rx(can_rx));

	// ****************************************
	// clock and tasks
	// ****************************************
	initial
	begin
		pclk = 1'b0;
		forever #50 pclk = ~pclk;
	end

	// one apb transfer, entered just after a rising edge
	task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		int n;
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		@(posedge pclk);
		penable <= 1'b1;
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'b1 && n < 50);
		rdat = prdata;
		rerr = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask

	task automatic cmp_val(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp)
		begin
			errors++;
			$display("[ERR] %0t value %h expected %h", $time, got, exp);
		end
	endtask

	task automatic cmp_cnt(input int got, input int exp);
		checked++;
		if (got != exp)
		begin
			errors++;
			$display("[ERR] %0t bit length %0d expected %0d", $time, got, exp);
		end
	endtask

	// counts edges up to the one that samples the next strobe
	task automatic strobe_gap(output int n);
		n = 0;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (sample_strobe !== 1'b1 && n < 2000);
	endtask

	// configure, hard-sync from idle, then time one bit of steady dominant
	task automatic bit_run(input logic [31:0] ext, input logic [31:0] cfg, input int exp);
		apb(1'b1, can_bit_timing_pkg::OFF_PRESCALER_EXT, ext);
		apb(1'b1, can_bit_timing_pkg::OFF_BIT_TIMING, cfg);
		apb(1'b1, can_bit_timing_pkg::OFF_LINK_CTRL, 32'h0000_0001);
		tx_bit <= 1'b0;
		u_node.hold_level(1'b0, 1);
		strobe_gap(gap);
		cmp_val({31'h0, tx_commit}, 32'h0000_0001);
		strobe_gap(gap);
		cmp_cnt(gap, exp);
		cmp_val({30'h0, sample_value, can_tx}, 32'h0000_0000);
		tx_bit <= 1'b1;
		// long recessive stretch so the link falls back to idle
		u_node.hold_level(1'b1, exp * 14);
	endtask

	task automatic print_verdict();
		if (errors == 0 && checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	// ****************************************
	// tests
	// ****************************************
	initial
	begin
		errors  = 0;
		checked = 0;
		presetn = 1'b0;
		psel    = 1'b0;
		penable = 1'b0;
		pwrite  = 1'b0;
		paddr   = 12'h000;
		pwdata  = 32'h0000_0000;
		tx_bit  = 1'b1;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		apb(1'b0, can_bit_timing_pkg::OFF_BIT_TIMING, 32'h0000_0000);
		cmp_val(rdat, {16'h0000, can_bit_timing_pkg::BIT_TIMING_RESET});
		apb(1'b0, can_bit_timing_pkg::OFF_PRESCALER_EXT, 32'h0000_0000);
		cmp_val(rdat, 32'h0000_0000);
		apb(1'b0, 12'h0100, 32'h0000_0000);
		cmp_val({31'h0, rerr}, 32'h0000_0001);
		apb(1'b1, can_bit_timing_pkg::OFF_BIT_TIMING, 32'hFFFF_FFFF);
		apb(1'b0, can_bit_timing_pkg::OFF_BIT_TIMING, 32'h0000_0000);
		cmp_val(rdat, 32'h0000_7FFF);
		apb(1'b1, can_bit_timing_pkg::OFF_PRESCALER_EXT, 32'hFFFF_FFFF);
		apb(1'b0, can_bit_timing_pkg::OFF_PRESCALER_EXT, 32'h0000_0000);
		cmp_val(rdat, 32'h0000_000F);
		// 2 clocks a quantum, 8 quanta: jump 2 within both phases
		bit_run(32'h0000_0000, 32'h0000_1441, (4 + 1 + 3) * (1 + 1));
		// extension lifts the prescaler to 65 clocks, 10 quanta
		bit_run(32'h0000_0001, 32'h0000_34C0, (4 + 3 + 3) * (64 + 1));
		print_verdict();
	end

	// hang guard, well past both bit runs
	initial
	begin
		repeat (30000) @(posedge pclk);
		errors++;
		print_verdict();
	end
endmodule // can_bit_timing_logic_tb_top
